// ===== bench/fixed_speed_partner.sv
`timescale 1ns/1ps
module fixed_speed_partner (
  // Clock and requested levels
  input wire logic ref_clk,
  input wire logic [7:0] diReq,
  input wire logic [15:0] fbReq,
  // Levels seen by the block
  output logic [7:0] digitalIn,
  output logic [15:0] fieldbusWord
);
  // Levels move just after the edge so the block never samples a change mid-edge
  initial {digitalIn, fieldbusWord} = 24'h000000;
  always @(posedge ref_clk) #1 {digitalIn, fieldbusWord} <= {diReq, fbReq};
endmodule

// ===== bench/fixed_speed_setpoint_select_assertions.sv
`timescale 1ns/1ps
module fixed_speed_setpoint_select_assertions (
  // Clock, reset, requests
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic valueWrEn,
  input wire logic [3:0] valueWrIndex,
  input wire logic [31:0] valueWrData,
  input wire logic modeWrEn,
  input wire logic [1:0] modeWrData,
  input wire logic [3:0] valueRdIndex,
  // Results
  input wire logic [31:0] activeFixedSpeed_q,
  input wire logic fixedSelectedFlag_q,
  input wire logic [3:0] selectBits_q,
  input wire logic [1:0] fixedSelectMode_q,
  input wire logic [31:0] valueRdData_q,
  input wire logic [19:0] selectSources_q
);
  // Single domain, so clock and reset are stated once
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_flag_tracks_bits: assert property (fixedSelectedFlag_q == (selectBits_q != 4'h0))
    else $error("flag wrong");
  a_mode_legal: assert property (fixedSelectMode_q == 2'h1 || fixedSelectMode_q == 2'h2)
    else $error("mode code wrong");
  a_mode_write: assert property (clkEn && modeWrEn && modeWrData inside {2'h1, 2'h2}
    |=> fixedSelectMode_q == $past(modeWrData)) else $error("mode not taken");
  a_mode_refused: assert property (!clkEn || (modeWrEn && !(modeWrData inside {2'h1, 2'h2}))
    |=> $stable(fixedSelectMode_q)) else $error("mode changed");
  a_freeze_hold: assert property (!clkEn |=> $stable(activeFixedSpeed_q) && $stable(selectBits_q))
    else $error("output moved while frozen");
  a_zero_select: assert property ($past(clkEn) && selectBits_q == 4'h0 |-> activeFixedSpeed_q == 32'h0)
    else $error("empty selection not zero");
  a_reset_state: assert property (disable iff (1'b0) !nrst |-> activeFixedSpeed_q == 32'h0
    && selectSources_q == 20'h0 && valueRdData_q == 32'h0 && fixedSelectMode_q == 2'h1) else $error("reset state");
  a_value_readback: assert property ((clkEn && valueWrEn && valueWrIndex != 4'h0
    && valueRdIndex == valueWrIndex) ##1 (clkEn && !valueWrEn && $stable(valueRdIndex))
    |=> valueRdData_q == $past(valueWrData, 2)) else $error("readback wrong");
endmodule
bind fixed_speed_setpoint_select fixed_speed_setpoint_select_assertions checker_i (.*);

// ===== bench/fixed_speed_setpoint_select_bench.sv
`timescale 1ns/1ps
module fixed_speed_setpoint_select_bench;
  logic ref_clk = 1'b0, nrst = 1'b1, clkEn = 1'b1, valueWrEn = 1'b0, modeWrEn = 1'b0, srcWrEn = 1'b0;
  logic fixedSelectedFlag_q;
  logic [1:0] modeWrData = 2'h0, srcWrIndex = 2'h0, fixedSelectMode_q;
  logic [3:0] valueWrIndex = 4'h0, valueRdIndex = 4'h7, selectBits_q;
  logic [4:0] srcWrData = 5'h00;
  logic [7:0] diReq = 8'h00, digitalIn;
  logic [15:0] fieldbusWord;
  logic [19:0] selectSources_q;
  logic [31:0] valueWrData = 32'h0, activeFixedSpeed_q, valueRdData_q;
  wire [15:0] fbReq = {8'h00, diReq};
  int miscompares = 0, checked = 0, cycles = 0;
  // Mode, digital inputs, expected setpoint
  logic [41:0] rows [10] = '{{2'h1, 8'h00, 32'h0}, {2'h1, 8'h01, 32'h12C}, {2'h1, 8'h02, 32'h7D0},
    {2'h1, 8'h03, 32'h8FC}, {2'h1, 8'h0F, 32'h2454}, {2'h1, 8'hF0, 32'h0}, {2'h2, 8'h05, 32'h1388},
    {2'h2, 8'h0F, 32'h3A98}, {2'h2, 8'h00, 32'h0}, {2'h2, 8'h01, 32'h12C}};
  always #12.5 ref_clk = ~ref_clk;
  fixed_speed_partner partner (.*);
  fixed_speed_setpoint_select DUT (.*);
  function automatic logic [31:0] vf(input logic [3:0] n);
    return n == 4'h1 ? 32'h12C : n == 4'h2 ? 32'h7D0 : 32'(n) * 32'h3E8;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Kind 0 value, 1 mode, 2 source; an idle edge, then strobe held one edge
  task automatic wr(input int k, input logic [3:0] i, input logic [31:0] d);
    @(posedge ref_clk) #2;
    {valueWrEn, modeWrEn, srcWrEn} = 3'b100 >> k;
    {valueWrIndex, valueWrData, modeWrData, srcWrIndex, srcWrData} = {i, d, d[1:0], i[1:0], d[4:0]};
    @(posedge ref_clk) #2;
    {valueWrEn, modeWrEn, srcWrEn} = 3'b000;
  endtask
  // Partner needs one edge, the block one more
  task automatic settle(input logic [7:0] di);
    @(posedge ref_clk) #2 diReq = di;
    repeat (3) @(posedge ref_clk);
    #2;
  endtask
  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand edges
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    // A real falling edge, so the asynchronous reset fires before the first clock
    #1 nrst = 1'b0;
    repeat (2) @(posedge ref_clk);
    #2;
    chk("mode", 32'h1, {30'h0, fixedSelectMode_q});
    chk("sources", 32'h0, {12'h0, selectSources_q});
    nrst = 1'b1;
    settle(8'h0F);
    chk("stored", 32'h0, valueRdData_q);
    chk("speed", 32'h0, activeFixedSpeed_q);
    for (int i = 0; i < 4; i++) wr(2, 4'(i), 32'h8 + 32'(i));
    for (int i = 1; i < 16; i++) wr(0, 4'(i), vf(4'(i)));
    settle(8'h00);
    chk("readback", vf(4'h7), valueRdData_q);
    chk("sources", {12'h0, 20'h5A928}, {12'h0, selectSources_q});
    foreach (rows[r]) begin
      if (fixedSelectMode_q !== rows[r][41:40]) wr(1, 4'h0, {30'h0, rows[r][41:40]});
      settle(rows[r][39:32]);
      chk("speed", rows[r][31:0], activeFixedSpeed_q);
      chk("flag", {31'h0, rows[r][35:32] != 4'h0}, {31'h0, fixedSelectedFlag_q});
      chk("bits", {28'h0, rows[r][35:32]}, {28'h0, selectBits_q});
    end
    $display("table done");
    wr(1, 4'h0, 32'h3);
    wr(1, 4'h0, 32'h0);
    settle(8'h05);
    chk("mode", 32'h2, {30'h0, fixedSelectMode_q});
    clkEn = 1'b0;
    settle(8'h0F);
    chk("frozen", 32'h1388, activeFixedSpeed_q);
    clkEn = 1'b1;
    wr(2, 4'h0, 32'h11);
    settle(8'h02);
    chk("fieldbus", 32'hBB8, activeFixedSpeed_q);
    wr(1, 4'h0, 32'h1);
    for (int i = 1; i < 5; i++) wr(0, 4'(i), 32'h7FFF_FFFF);
    settle(8'h0D);
    chk("saturated", 32'h7FFF_FFFF, activeFixedSpeed_q);
    // Index zero write is refused; constant-one source selects bit 1 alone
    wr(0, 4'h0, 32'h1234);
    wr(2, 4'h1, 32'h1);
    valueRdIndex = 4'h0;
    settle(8'h00);
    chk("const one", 32'h7FFF_FFFF, activeFixedSpeed_q);
    chk("index zero", 32'h0, valueRdData_q);
    $display("special cases done");
    complete_run();
  end
endmodule

// ===== rtl/fixed_speed_pkg.sv
package fixed_speed_pkg;

  // Speed values are signed rpm in a fixed-point word
  localparam int SPEED_W = 32;
  localparam int SEL_BITS = 4;
  localparam int NUM_VALUES = 15;
  localparam int IDX_W = 4;

  // Mode encodings and reset value
  localparam logic [1:0] MODE_DIRECT = 2'h1;
  localparam logic [1:0] MODE_BINARY = 2'h2;
  localparam logic [1:0] MODE_RESET = MODE_DIRECT;

  // Signal source codes for each selection bit
  localparam int SRC_W = 5;
  localparam logic [SRC_W-1:0] SRC_ZERO = 5'h00;
  localparam logic [SRC_W-1:0] SRC_ONE = 5'h01;
  localparam logic [SRC_W-1:0] SRC_DI_BASE = 5'h08;
  localparam logic [SRC_W-1:0] SRC_FB_BASE = 5'h10;
  localparam logic [SRC_W-1:0] SRC_RESET = SRC_ZERO;
  localparam int DI_W = 8;
  localparam int FB_W = 16;

  // Reset value of stored data and saturation limits
  localparam logic [SPEED_W-1:0] SPEED_RESET = 32'h0000_0000;
  localparam logic [SPEED_W-1:0] SPEED_MAX = 32'h7FFF_FFFF;
  localparam logic [SPEED_W-1:0] SPEED_MIN = 32'h8000_0000;

endpackage

// ===== rtl/fixed_speed_setpoint_select.sv
`timescale 1ns/1ps
module fixed_speed_setpoint_select (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // Selection signal candidates
  input wire logic [fixed_speed_pkg::DI_W-1:0] digitalIn,
  input wire logic [fixed_speed_pkg::FB_W-1:0] fieldbusWord,
  // Fixed speed value write port, index 1 to 15
  input wire logic valueWrEn,
  input wire logic [fixed_speed_pkg::IDX_W-1:0] valueWrIndex,
  input wire logic [fixed_speed_pkg::SPEED_W-1:0] valueWrData,
  // Mode write port
  input wire logic modeWrEn,
  input wire logic [1:0] modeWrData,
  // Selection source write port
  input wire logic srcWrEn,
  input wire logic [1:0] srcWrIndex,
  input wire logic [fixed_speed_pkg::SRC_W-1:0] srcWrData,
  // Value readback request
  input wire logic [fixed_speed_pkg::IDX_W-1:0] valueRdIndex,
  // Results
  output logic [fixed_speed_pkg::SPEED_W-1:0] activeFixedSpeed_q,
  output logic fixedSelectedFlag_q,
  output logic [fixed_speed_pkg::SEL_BITS-1:0] selectBits_q,
  // Configuration readback
  output logic [1:0] fixedSelectMode_q,
  output logic [fixed_speed_pkg::SPEED_W-1:0] valueRdData_q,
  output logic [fixed_speed_pkg::SRC_W*fixed_speed_pkg::SEL_BITS-1:0] selectSources_q
);

  localparam int SUM_W = fixed_speed_pkg::SPEED_W + 2;

  logic [fixed_speed_pkg::SPEED_W-1:0] speedValue_q [1:fixed_speed_pkg::NUM_VALUES];
  logic [fixed_speed_pkg::SRC_W-1:0] srcCode_q [0:fixed_speed_pkg::SEL_BITS-1];
  logic [fixed_speed_pkg::SEL_BITS-1:0] selBits;
  logic signed [SUM_W-1:0] directSum;
  logic [fixed_speed_pkg::SPEED_W-1:0] directSat;
  logic [fixed_speed_pkg::SPEED_W-1:0] binaryValue;
  logic [fixed_speed_pkg::SPEED_W-1:0] activeFixedSpeed_d;
  logic fixedSelectedFlag_d;

  // One source mux per selection bit
  genvar gi;
  generate
    for (gi = 0; gi < fixed_speed_pkg::SEL_BITS; gi++) begin : gSel
      select_source_mux uMux (
        .srcCode(srcCode_q[gi]),
        .digitalIn(digitalIn),
        .fieldbusWord(fieldbusWord),
        .selBit(selBits[gi])
      );
    end
  endgenerate

  // Stored fixed speed values; index zero has no storage
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 1; i <= fixed_speed_pkg::NUM_VALUES; i++) begin
        speedValue_q[i] <= fixed_speed_pkg::SPEED_RESET;
      end
    end else if (clkEn && valueWrEn && (valueWrIndex != 4'h0)) begin
      speedValue_q[valueWrIndex] <= valueWrData;
    end
  end

  // Mode setting; codes other than direct or binary are ignored
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fixedSelectMode_q <= fixed_speed_pkg::MODE_RESET;
    end else if (clkEn && modeWrEn) begin
      if ((modeWrData == fixed_speed_pkg::MODE_DIRECT) || (modeWrData == fixed_speed_pkg::MODE_BINARY)) begin
        fixedSelectMode_q <= modeWrData;
      end
    end
  end

  // Selection source codes, all constant zero after reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < fixed_speed_pkg::SEL_BITS; i++) begin
        srcCode_q[i] <= fixed_speed_pkg::SRC_RESET;
      end
    end else if (clkEn && srcWrEn) begin
      srcCode_q[srcWrIndex] <= srcWrData;
    end
  end

  // Direct sum; two guard bits so four values cannot wrap
  always_comb begin
    directSum = '0;
    for (int i = 0; i < fixed_speed_pkg::SEL_BITS; i++) begin
      if (selBits[i]) begin
        directSum = directSum + SUM_W'($signed(speedValue_q[i+1]));
      end
    end
  end

  // Clamp to the word range rather than wrap into the opposite direction
  always_comb begin
    if (directSum > $signed(SUM_W'($signed(fixed_speed_pkg::SPEED_MAX)))) begin
      directSat = fixed_speed_pkg::SPEED_MAX;
    end else if (directSum < $signed(SUM_W'($signed(fixed_speed_pkg::SPEED_MIN)))) begin
      directSat = fixed_speed_pkg::SPEED_MIN;
    end else begin
      directSat = directSum[fixed_speed_pkg::SPEED_W-1:0];
    end
  end

  // Binary choice, bit 0 least significant, code zero gives zero
  always_comb begin
    binaryValue = fixed_speed_pkg::SPEED_RESET;
    if (selBits != 4'h0) begin
      binaryValue = speedValue_q[selBits];
    end
  end

  // Mode decides result; status flag is set by any selection bit in either mode
  always_comb begin
    fixedSelectedFlag_d = (selBits != 4'h0);
    if (fixedSelectMode_q == fixed_speed_pkg::MODE_BINARY) begin
      activeFixedSpeed_d = binaryValue;
    end else begin
      activeFixedSpeed_d = directSat;
    end
  end

  // Registered result for the setpoint channel
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      activeFixedSpeed_q <= fixed_speed_pkg::SPEED_RESET;
    end else if (clkEn) begin
      activeFixedSpeed_q <= activeFixedSpeed_d;
    end
  end

  // Registered status flag and current selection bits
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fixedSelectedFlag_q <= 1'b0;
      selectBits_q <= 4'h0;
    end else if (clkEn) begin
      fixedSelectedFlag_q <= fixedSelectedFlag_d;
      selectBits_q <= selBits;
    end
  end

  // Value readback; index zero reads zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      valueRdData_q <= fixed_speed_pkg::SPEED_RESET;
    end else if (clkEn) begin
      if (valueRdIndex == 4'h0) begin
        valueRdData_q <= fixed_speed_pkg::SPEED_RESET;
      end else begin
        valueRdData_q <= speedValue_q[valueRdIndex];
      end
    end
  end

  // Source code readback, bit 0 source in the low field
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      selectSources_q <= '0;
    end else if (clkEn) begin
      for (int i = 0; i < fixed_speed_pkg::SEL_BITS; i++) begin
        selectSources_q[i*fixed_speed_pkg::SRC_W +: fixed_speed_pkg::SRC_W] <= srcCode_q[i];
      end
    end
  end

endmodule

// ===== rtl/select_source_mux.sv
`timescale 1ns/1ps
module select_source_mux (
  // Source configuration
  input wire logic [fixed_speed_pkg::SRC_W-1:0] srcCode,
  // Candidate signals
  input wire logic [fixed_speed_pkg::DI_W-1:0] digitalIn,
  input wire logic [fixed_speed_pkg::FB_W-1:0] fieldbusWord,
  // Selected binary signal
  output logic selBit
);

  // Unused codes read as constant zero so a bad setting selects nothing
  always_comb begin
    selBit = 1'b0;
    if (srcCode == fixed_speed_pkg::SRC_ONE) begin
      selBit = 1'b1;
    end else if (srcCode >= fixed_speed_pkg::SRC_FB_BASE) begin
      selBit = fieldbusWord[srcCode[3:0]];
    end else if (srcCode >= fixed_speed_pkg::SRC_DI_BASE) begin
      selBit = digitalIn[srcCode[2:0]];
    end
  end

endmodule
